// ### bhfo_history.sv
`timescale 1ns/1ps
`include "bhfo_regs.svh"

module bhfo_history (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  // Control
  input  wire logic               clear_in,
  input  wire logic               update_in,
  input  wire bhfo_pkg::bhfo_group_t flags_in,
  // Status
  output logic [31:0]             status_out
);

  logic [31:0] status_q;
  logic [31:0] status_d;

  // ----------------------------------------------------------------------
  // Two-deep history
  // ----------------------------------------------------------------------

  // Clear beats shift; shift moves current into older, loads current
  always_comb begin
    status_d = status_q;
    if (clear_in) begin
      status_d = `BHFO_BOOT_RST;
    end else if (update_in) begin
      status_d = `BHFO_BOOT_RST;
      status_d[`BHFO_OLD_LSB +: `BHFO_GROUP_W] =
        status_q[`BHFO_CUR_LSB +: `BHFO_GROUP_W];
      status_d[`BHFO_CUR_LSB +: `BHFO_GROUP_W] = flags_in;
    end
  end

  // Register stage
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_q <= `BHFO_BOOT_RST;
    end else begin
      status_q <= status_d;
    end
  end

  assign status_out = status_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_clear_all: assert property (clear_in |=> status_q == 32'h00000000)
    else $error("history not cleared");
  a_shift_order: assert property (!clear_in && update_in |=>
    status_q[14:8] == $past(status_q[6:0]) && status_q[6:0] == $past(flags_in))
    else $error("history shift wrong");
  a_layout_zero: assert property (status_q[31:15] == 17'h00000 && !status_q[7])
    else $error("reserved history bits set");
  a_hold_quiet: assert property (!clear_in && !update_in |=> $stable(status_q))
    else $error("history changed without cause");
  c_shift_twice: cover property (update_in ##1 update_in);

endmodule

// ### bhfo_pkg.sv
package bhfo_pkg;

  // Avalon slave answer sequencing
  typedef enum logic {
    bhfo_st_idle,
    bhfo_st_answer
  } bhfo_bus_state_e;

  // One boot history group
  typedef logic [6:0] bhfo_group_t;

endpackage

// ### bhfo_regs.svh
`ifndef BHFO_REGS_SVH
`define BHFO_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define BHFO_IDX_W          6
`define BHFO_IDX_BOOT       6'h16
`define BHFO_IDX_CTL        6'h18
`define BHFO_IDX_FLASH      6'h1F
`define BHFO_IDX_WMASK      6'h20
`define BHFO_IDX_IRQ_STAT   6'h21
`define BHFO_IDX_IRQ_MASK   6'h22

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BHFO_BOOT_RST       32'h00000000
`define BHFO_FLASH_RST      32'h0000000B
`define BHFO_WMASK_RST      32'h00000000
`define BHFO_UNMAPPED_DATA  32'h00000000

// ----------------------------------------------------------------------
// Boot history layout
// ----------------------------------------------------------------------
`define BHFO_GROUP_W        7
`define BHFO_OLD_LSB        8
`define BHFO_CUR_LSB        0
`define BHFO_FLAG_FALLBACK  1

// ----------------------------------------------------------------------
// Control one and flash options fields
// ----------------------------------------------------------------------
`define BHFO_CAPTURE_BIT    23
`define BHFO_SYNC_BIT       27
`define BHFO_RCR_MSB        26
`define BHFO_RCR_LSB        12
`define BHFO_WIDE_BIT       10
`define BHFO_LANE_MSB       9
`define BHFO_LANE_LSB       8
`define BHFO_CMD_MSB        7
`define BHFO_FLASH_WMASK    32'h0FFFF7FF

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define BHFO_IRQ_W          3
`define BHFO_IRQ_UPDATE     0
`define BHFO_IRQ_ERROR      1
`define BHFO_IRQ_FALLBACK   2

`endif

// ### bhfo_sticky.sv
`timescale 1ns/1ps
`include "bhfo_regs.svh"

module bhfo_sticky #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          reset_in,
  // Events and software
  input  wire logic [W-1:0]  set_in,
  input  wire logic [W-1:0]  clear_in,
  input  wire logic [W-1:0]  mask_in,
  // Results
  output logic [W-1:0]       status_out,
  output logic               irq_out
);

  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    flag_d = (flag_q & ~clear_in) | set_in;
  end

  // Register stage
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign status_out = flag_q;
  assign irq_out    = |(flag_q & mask_in);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_set_wins: assert property (|set_in |=> (flag_q & $past(set_in)) == $past(set_in))
    else $error("event lost against clear");
  a_irq_level: assert property (|(set_in & mask_in) |=>
    irq_out || (mask_in != $past(mask_in)))
    else $error("interrupt level wrong");
  a_w1c_clear: assert property (|(clear_in & ~set_in) |=>
    (flag_q & $past(clear_in) & ~$past(set_in)) == {W{1'b0}})
    else $error("written one did not clear");

endmodule

// ### bhfo_top.sv
`timescale 1ns/1ps
`include "bhfo_regs.svh"

// Overview of operation
// - History clears only on power-on or reconfiguration requests
// - Startup end or error shifts history groups
// - Group flags wrap to valid; reserved bit seven
// - Wraparound error counted only in asynchronous read
// - Fallback sets flag, drives revision select low
// - Set history bit means condition was detected
// - Control writes change only mask-enabled bits
// - Only capture bit twenty-three lives, resets zero
// - Bit twenty-seven selects synchronous parallel read
// - Bits twenty-six to twelve: read-configuration word
// - Bit ten selects 32-bit serial addressing
// - Bits nine to eight: serial lane count
// - Bits seven to zero: serial read command
module bhfo_top (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Configuration events
  input  wire logic        end_of_startup_in,
  input  wire logic        crc_error_in,
  input  wire logic        identity_error_in,
  input  wire logic        watchdog_timeout_in,
  input  wire logic        flash_addr_wrap_in,
  input  wire logic        internal_reconfig_in,
  input  wire logic        fallback_in,
  // Reconfiguration requests
  input  wire logic        full_reconfig_n_in,
  input  wire logic        jtag_reconfig_instruction_in,
  // Option outputs
  output logic             readback_capture_en_out,
  output logic             parallel_flash_sync_read_out,
  output logic [14:0]      parallel_flash_read_config_word_out,
  output logic             serial_flash_wide_address_out,
  output logic [1:0]       serial_flash_lane_count_out,
  output logic [7:0]       serial_flash_read_command_out,
  // Revision select pins
  output logic [1:0]       revision_select_out,
  output logic [1:0]       revision_select_oe_out,
  // Interrupt
  output logic             irq_out
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  bhfo_pkg::bhfo_bus_state_e state_q;
  bhfo_pkg::bhfo_bus_state_e state_d;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;
  logic                      capture_q;
  logic                      capture_d;
  logic [31:0]               flash_q;
  logic [31:0]               flash_d;
  logic [31:0]               wmask_q;
  logic [31:0]               wmask_d;
  logic [`BHFO_IRQ_W-1:0]    irq_mask_q;
  logic [`BHFO_IRQ_W-1:0]    irq_mask_d;
  logic [31:0]               be_bits;
  logic [31:0]               ctl_wbits;
  logic [`BHFO_IDX_W-1:0]    idx;
  logic                      aligned;
  logic                      wr_fire;
  logic                      wrap_evt;
  logic                      err_evt;
  logic                      hist_update;
  logic                      hist_clear;
  logic [31:0]               boot_status;
  bhfo_pkg::bhfo_group_t     hist_flags;
  logic [`BHFO_IRQ_W-1:0]    irq_set;
  logic [`BHFO_IRQ_W-1:0]    irq_clear;
  logic [`BHFO_IRQ_W-1:0]    irq_status;

  // ----------------------------------------------------------------------
  // Address decode and byte lanes
  // ----------------------------------------------------------------------

  // Word index and alignment of the request
  assign idx     = avs_address_in[7:2];
  assign aligned = (avs_address_in[1:0] == 2'h0);

  // Byte enables widened to bit lanes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      be_bits[i*8 +: 8] = {8{avs_byteenable_in[i]}};
    end
  end

  // Write commits on the edge where waitrequest is sampled low
  assign wr_fire   = (state_q == bhfo_pkg::bhfo_st_answer) && avs_write_in;
  assign ctl_wbits = wmask_q & be_bits;

  // ----------------------------------------------------------------------
  // Bus answer sequencing
  // ----------------------------------------------------------------------

  // One wait cycle per access; read data captured on entry to answer
  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    case (state_q)
      bhfo_pkg::bhfo_st_idle: begin
        if (avs_read_in || avs_write_in) begin
          state_d = bhfo_pkg::bhfo_st_answer;
          rdata_d = `BHFO_UNMAPPED_DATA;
          if (avs_read_in && aligned) begin
            case (idx)
              `BHFO_IDX_BOOT:     rdata_d = boot_status;
              `BHFO_IDX_CTL:      rdata_d[`BHFO_CAPTURE_BIT] = capture_q;
              `BHFO_IDX_FLASH:    rdata_d = flash_q;
              `BHFO_IDX_WMASK:    rdata_d = wmask_q;
              `BHFO_IDX_IRQ_STAT: rdata_d[`BHFO_IRQ_W-1:0] = irq_status;
              `BHFO_IDX_IRQ_MASK: rdata_d[`BHFO_IRQ_W-1:0] = irq_mask_q;
              default:            rdata_d = `BHFO_UNMAPPED_DATA;
            endcase
          end
        end
      end
      bhfo_pkg::bhfo_st_answer: begin
        state_d = bhfo_pkg::bhfo_st_idle;
      end
      default: begin
        state_d = bhfo_pkg::bhfo_st_idle;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= bhfo_pkg::bhfo_st_idle;
      rdata_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest_out = (avs_read_in || avs_write_in) &&
                               (state_q == bhfo_pkg::bhfo_st_idle);
  assign avs_readdata_out    = rdata_q;

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------

  // Writes per register; the history register has no write path
  always_comb begin
    capture_d  = capture_q;
    flash_d    = flash_q;
    wmask_d    = wmask_q;
    irq_mask_d = irq_mask_q;
    irq_clear  = '0;
    if (wr_fire && aligned) begin
      case (idx)
        `BHFO_IDX_CTL: begin
          if (ctl_wbits[`BHFO_CAPTURE_BIT]) begin
            capture_d = avs_writedata_in[`BHFO_CAPTURE_BIT];
          end
        end
        `BHFO_IDX_FLASH: begin
          flash_d = ((flash_q & ~be_bits) | (avs_writedata_in & be_bits)) &
                    `BHFO_FLASH_WMASK;
        end
        `BHFO_IDX_WMASK: begin
          wmask_d = (wmask_q & ~be_bits) | (avs_writedata_in & be_bits);
        end
        `BHFO_IDX_IRQ_STAT: begin
          irq_clear = avs_writedata_in[`BHFO_IRQ_W-1:0] & be_bits[`BHFO_IRQ_W-1:0];
        end
        `BHFO_IDX_IRQ_MASK: begin
          if (avs_byteenable_in[0]) begin
            irq_mask_d = avs_writedata_in[`BHFO_IRQ_W-1:0];
          end
        end
        default: begin
          capture_d = capture_q;
        end
      endcase
    end
  end

  // Register stage
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      capture_q  <= 1'b0;
      flash_q    <= `BHFO_FLASH_RST;
      wmask_q    <= `BHFO_WMASK_RST;
      irq_mask_q <= '0;
    end else begin
      capture_q  <= capture_d;
      flash_q    <= flash_d;
      wmask_q    <= wmask_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // Option fields driven straight from the registers
  assign readback_capture_en_out             = capture_q;
  assign parallel_flash_sync_read_out        = flash_q[`BHFO_SYNC_BIT];
  assign parallel_flash_read_config_word_out = flash_q[`BHFO_RCR_MSB:`BHFO_RCR_LSB];
  assign serial_flash_wide_address_out       = flash_q[`BHFO_WIDE_BIT];
  assign serial_flash_lane_count_out         = flash_q[`BHFO_LANE_MSB:`BHFO_LANE_LSB];
  assign serial_flash_read_command_out       = flash_q[`BHFO_CMD_MSB:0];

  // ----------------------------------------------------------------------
  // Boot history capture
  // ----------------------------------------------------------------------

  // Wraparound counts only while flash is read asynchronously
  assign wrap_evt    = flash_addr_wrap_in && !flash_q[`BHFO_SYNC_BIT];
  assign err_evt     = wrap_evt || crc_error_in || identity_error_in ||
                       watchdog_timeout_in;
  assign hist_update = end_of_startup_in || err_evt;
  assign hist_clear  = !full_reconfig_n_in || jtag_reconfig_instruction_in;
  assign hist_flags  = {wrap_evt, crc_error_in, identity_error_in,
                        watchdog_timeout_in, internal_reconfig_in,
                        fallback_in, 1'b1};

  bhfo_history u_history (
    .clk_in     (core_clk_in),
    .reset_in   (reset_in),
    .clear_in   (hist_clear),
    .update_in  (hist_update),
    .flags_in   (hist_flags),
    .status_out (boot_status)
  );

  // Fallback drives both revision select pins low
  assign revision_select_out    = 2'h0;
  assign revision_select_oe_out = {2{boot_status[`BHFO_FLAG_FALLBACK]}};

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------

  // Events into sticky status
  always_comb begin
    irq_set                     = '0;
    irq_set[`BHFO_IRQ_UPDATE]   = hist_update && !hist_clear;
    irq_set[`BHFO_IRQ_ERROR]    = err_evt && !hist_clear;
    irq_set[`BHFO_IRQ_FALLBACK] = hist_update && fallback_in && !hist_clear;
  end

  bhfo_sticky #(
    .W (`BHFO_IRQ_W)
  ) u_sticky (
    .clk_in     (core_clk_in),
    .reset_in   (reset_in),
    .set_in     (irq_set),
    .clear_in   (irq_clear),
    .mask_in    (irq_mask_q),
    .status_out (irq_status),
    .irq_out    (irq_out)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_wait_first: assert property ((state_q == bhfo_pkg::bhfo_st_idle) && avs_read_in
    |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("answer timing wrong");
  a_ctl_masked: assert property (wr_fire && idx == `BHFO_IDX_CTL &&
    !ctl_wbits[`BHFO_CAPTURE_BIT] |=> $stable(capture_q))
    else $error("masked control bit changed");
  a_ctl_reserved: assert property (avs_read_in && !avs_waitrequest_out &&
    $past(idx) == `BHFO_IDX_CTL && $past(aligned) |->
    (avs_readdata_out & 32'hFF7FFFFF) == 32'h00000000)
    else $error("control reserved bits nonzero");
  a_boot_readonly: assert property (wr_fire && !hist_update && !hist_clear
    |=> $stable(boot_status))
    else $error("history written by bus");
  a_wrap_sync_off: assert property (flash_addr_wrap_in && flash_q[`BHFO_SYNC_BIT] &&
    !crc_error_in && !identity_error_in && !watchdog_timeout_in &&
    !end_of_startup_in && !hist_clear |=> $stable(boot_status))
    else $error("wrap counted in synchronous read");
  a_fallback_pins: assert property (hist_update && fallback_in && !hist_clear
    |=> revision_select_oe_out == 2'h3 && revision_select_out == 2'h0)
    else $error("fallback pins not driven low");
  a_valid_set: assert property (hist_update && !hist_clear |=> boot_status[0])
    else $error("valid flag not set");
  a_flash_write: assert property (wr_fire && aligned && idx == `BHFO_IDX_FLASH &&
    avs_byteenable_in == 4'hF |=>
    flash_q == ($past(avs_writedata_in) & `BHFO_FLASH_WMASK))
    else $error("flash options write wrong");

  // ----------------------------------------------------------------------
  // Read path and history flag checks
  // ----------------------------------------------------------------------

  // Read answers carry the word captured when the request was taken
  a_boot_readback: assert property (avs_read_in && !avs_waitrequest_out &&
    $past(idx) == `BHFO_IDX_BOOT && $past(aligned) |->
    avs_readdata_out == $past(boot_status))
    else $error("history readback wrong");
  a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out &&
    !$past(aligned) |-> avs_readdata_out == `BHFO_UNMAPPED_DATA)
    else $error("misaligned read not zero");

  // A misaligned write must reach no register at all
  a_misaligned_wr: assert property (wr_fire && !aligned |=>
    $stable(flash_q) && $stable(wmask_q) && $stable(capture_q) && $stable(irq_mask_q))
    else $error("misaligned write landed");

  // Every source lands in its own flag of the current group
  a_wrap_flag: assert property (wrap_evt && !hist_clear |=> boot_status[6])
    else $error("wraparound flag missing");
  a_crc_flag: assert property (crc_error_in && !hist_clear |=> boot_status[5])
    else $error("checksum flag missing");
  a_ident_flag: assert property (identity_error_in && !hist_clear |=>
    boot_status[4])
    else $error("identity flag missing");
  a_timeout_flag: assert property (watchdog_timeout_in && !hist_clear |=>
    boot_status[3])
    else $error("timeout flag missing");
  a_internal_flag: assert property (hist_update && !hist_clear |=>
    boot_status[2] == $past(internal_reconfig_in))
    else $error("internal reconfiguration flag wrong");
  a_fallback_flag: assert property (hist_update && !hist_clear |=>
    boot_status[1] == $past(fallback_in))
    else $error("fallback flag wrong");

  c_boot_read: cover property (avs_read_in && idx == `BHFO_IDX_BOOT && !avs_waitrequest_out);
  c_capture_on: cover property ($rose(readback_capture_en_out));
  c_fallback: cover property ($rose(revision_select_oe_out[0]));
  c_irq: cover property ($rose(irq_out));

endmodule

// ### bhfo_top_tb.sv
`timescale 1ns/1ps
`include "bhfo_regs.svh"

module bhfo_top_tb;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        core_clk_in;
  logic        reset_in;
  logic [7:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        startup_in;
  logic        crc_in;
  logic        id_in;
  logic        wd_in;
  logic        wrap_in;
  logic        internal_in;
  logic        fallback_in;
  logic        full_n_in;
  logic        jtag_in;
  logic        capture_out;
  logic        sync_out;
  logic [14:0] rcr_out;
  logic        wide_out;
  logic [1:0]  lanes_out;
  logic [7:0]  cmd_out;
  logic [1:0]  sel_out;
  logic [1:0]  sel_oe_out;
  logic        irq_out;
  int          mismatches;
  int          checks_done;
  logic [31:0] rdata;
  logic [31:0] row_w [6];
  logic [31:0] row_e [6];

  // ------------------------------------------------------------------
  // Design
  // ------------------------------------------------------------------
  bhfo_top bhfo_top_inst (
    .core_clk_in                         (core_clk_in),
    .reset_in                            (reset_in),
    .avs_address_in                      (avs_address_in),
    .avs_read_in                         (avs_read_in),
    .avs_write_in                        (avs_write_in),
    .avs_writedata_in                    (avs_writedata_in),
    .avs_byteenable_in                   (avs_byteenable_in),
    .avs_readdata_out                    (avs_readdata_out),
    .avs_waitrequest_out                 (avs_waitrequest_out),
    .end_of_startup_in                   (startup_in),
    .crc_error_in                        (crc_in),
    .identity_error_in                   (id_in),
    .watchdog_timeout_in                 (wd_in),
    .flash_addr_wrap_in                  (wrap_in),
    .internal_reconfig_in                (internal_in),
    .fallback_in                         (fallback_in),
    .full_reconfig_n_in                  (full_n_in),
    .jtag_reconfig_instruction_in        (jtag_in),
    .readback_capture_en_out             (capture_out),
    .parallel_flash_sync_read_out        (sync_out),
    .parallel_flash_read_config_word_out (rcr_out),
    .serial_flash_wide_address_out       (wide_out),
    .serial_flash_lane_count_out         (lanes_out),
    .serial_flash_read_command_out       (cmd_out),
    .revision_select_out                 (sel_out),
    .revision_select_oe_out              (sel_oe_out),
    .irq_out                             (irq_out)
  );

  // ------------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // Whole run needs a few hundred cycles; this is far beyond it
  initial begin
    #100000;
    mismatches = mismatches + 1;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    $display("mismatches %0d, checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    do begin
      @(posedge core_clk_in);
      n = n + 1;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches = mismatches + 1;
      $display("BAD %0t bus answer missing", $time);
    end
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    @(posedge core_clk_in);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h00000000, rdata);
  endtask

  // Pulse of events {startup, crc, id, watchdog, wrap}, then let history settle
  task automatic ev(input logic [4:0] v);
    @(posedge core_clk_in);
    {startup_in, crc_in, id_in, wd_in, wrap_in} <= v;
    @(posedge core_clk_in);
    {startup_in, crc_in, id_in, wd_in, wrap_in} <= 5'h00;
    @(posedge core_clk_in);
    @(posedge core_clk_in);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    mismatches = 0;
    checks_done = 0;
    reset_in = 1'b1;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h00000000;
    avs_byteenable_in = 4'hF;
    {startup_in, crc_in, id_in, wd_in, wrap_in} = 5'h00;
    internal_in = 1'b0;
    fallback_in = 1'b0;
    full_n_in = 1'b1;
    jtag_in = 1'b0;
    row_w = '{32'hFFFFFFFF, 32'h00000100, 32'h00000200, 32'h08000400,
              32'h0555A03B, 32'h0000000B};
    row_e = '{32'h0FFFF7FF, 32'h00000100, 32'h00000200, 32'h08000400,
              32'h0555A03B, 32'h0000000B};
    repeat (8) @(posedge core_clk_in);
    chk({4'h0, sync_out, rcr_out, 1'b0, wide_out, lanes_out, cmd_out}, 32'h0000000B);
    chk({29'h0, capture_out, sel_oe_out}, 32'h00000000);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    rd(8'h58); chk(rdata, 32'h00000000);
    rd(8'h60); chk(rdata, 32'h00000000);
    rd(8'h7C); chk(rdata, 32'h0000000B);
    rd(8'h04); chk(rdata, 32'h00000000);
    rd(8'h61); chk(rdata, 32'h00000000);
    // Flash option rows: readback and decoded outputs
    foreach (row_w[i]) begin
      wr(8'h7C, row_w[i]);
      chk({4'h0, sync_out, rcr_out, 1'b0, wide_out, lanes_out, cmd_out},
          row_e[i]);
      rd(8'h7C); chk(rdata, row_e[i]);
    end
    // Misaligned write must leave the options alone
    wr(8'h7D, 32'hFFFFFFFF);
    rd(8'h7C); chk(rdata, 32'h0000000B);
    // Control one behind its write mask
    wr(8'h60, 32'hFFFFFFFF);
    rd(8'h60); chk(rdata, 32'h00000000);
    wr(8'h80, 32'h00800000);
    wr(8'h60, 32'hFFFFFFFF);
    rd(8'h60); chk(rdata, 32'h00800000);
    chk({31'h0, capture_out}, 32'h00000001);
    wr(8'h80, 32'h00000000);
    wr(8'h60, 32'h00000000);
    chk({31'h0, capture_out}, 32'h00000001);
    // History shifting and interrupts
    wr(8'h88, 32'h00000007);
    ev(5'h10);
    rd(8'h58); chk(rdata, 32'h00000001);
    rd(8'h84); chk(rdata, 32'h00000001);
    chk({31'h0, irq_out}, 32'h00000001);
    wr(8'h88, 32'h00000000);
    chk({31'h0, irq_out}, 32'h00000000);
    wr(8'h88, 32'h00000007);
    chk({31'h0, irq_out}, 32'h00000001);
    wr(8'h84, 32'h00000001);
    chk({31'h0, irq_out}, 32'h00000000);
    rd(8'h84); chk(rdata, 32'h00000000);
    ev(5'h11);
    rd(8'h58); chk(rdata, 32'h00000141);
    wr(8'h84, 32'h00000007);
    internal_in <= 1'b1;
    fallback_in <= 1'b1;
    ev(5'h08);
    rd(8'h58); chk(rdata, 32'h00004127);
    chk({28'h0, sel_oe_out, sel_out}, 32'h0000000C);
    rd(8'h84); chk(rdata, 32'h00000007);
    wr(8'h58, 32'hFFFFFFFF);
    rd(8'h58); chk(rdata, 32'h00004127);
    internal_in <= 1'b0;
    fallback_in <= 1'b0;
    wr(8'h7C, 32'h08000000);
    // Lone wraparound in synchronous read must not shift history
    ev(5'h01);
    rd(8'h58); chk(rdata, 32'h00004127);
    ev(5'h11);
    rd(8'h58); chk(rdata, 32'h00002701);
    chk({28'h0, sel_oe_out, sel_out}, 32'h00000000);
    ev(5'h04);
    ev(5'h02);
    rd(8'h58); chk(rdata, 32'h00001109);
    // Clearing sources
    @(posedge core_clk_in);
    jtag_in <= 1'b1;
    @(posedge core_clk_in);
    jtag_in <= 1'b0;
    rd(8'h58); chk(rdata, 32'h00000000);
    ev(5'h10);
    @(posedge core_clk_in);
    full_n_in <= 1'b0;
    @(posedge core_clk_in);
    full_n_in <= 1'b1;
    rd(8'h58); chk(rdata, 32'h00000000);
    finish_test();
  end

endmodule
